// ### hdl/clock_calendar_sram_i2c_access.sv
// two-wire target access to the clock registers, sram and power-fail time-stamps
`timescale 1ns/1ps

// Summary of operation
// - stamp minutes BCD, bit 7 zero
// - hours bit 6 format, bit 5 afternoon
// - 12-hour tens digit is bit 4
// - 24-hour tens bits 5-4, bit 7 zero
// - stamp date BCD, bits 7-6 zero
// - month bits 7-5 carry weekday
// - month tens bit 4, ones bits 3-0
// - own control code only; protected code ignored
// - clock 0x00-0x1F, sram 0x20-0x5F
// - sram access regardless of clock updates
// - reset leaves sram contents alone
// - no bus access on backup supply
// - byte write: control, address, data, ack each
// - address above 0x5F: no ack, no store
// - pointer ends after written location
// - each data byte acked, stored, pointer incremented
// - sequential write has no byte limit
// - pointer wraps within its block
// - current read returns pointer location
// - read: ack control, send one byte
// - pointer shared with protected space
// - capture stamps on loss and return, set flag
// - new stamps only after flag cleared
// - clearing flag zeroes all stamp registers
module clock_calendar_sram_i2c_access
   import clock_calendar_sram_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic on_backup_i,
   input wire logic oscillator_running_flag_i,
   input wire stamp_set_type clock_calendar_now_i,
   input wire logic pointer_load_i,
   input wire logic [7:0] pointer_value_i,
   output logic [7:0] pointer_o,
   output logic power_loss_flag_o,
   output logic backup_supply_enable_o
);

   logic rst_meta_q;
   logic rst_n;
   logic scl_meta_q, scl_sync_q, scl_del_q;
   logic sda_meta_q, sda_sync_q, sda_del_q;
   logic bak_meta_q, bak_sync_q, bak_del_q;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic backup_rise, backup_fall;

   bus_state_type state_q;
   logic [3:0] cnt_q;
   logic ack_phase_q;
   logic drive_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic [7:0] ptr_next;
   logic [7:0] clock_regs_q [CLOCK_DEPTH];
   logic [7:0] sram_q [SRAM_DEPTH];
   logic [5:0] sram_idx;
   logic [7:0] rd_byte;
   logic [7:0] status_view;
   logic power_loss_q;
   logic armed_q;
   logic rd_tail_q;

   logic byte_done, ctrl_hit, addr_ok;
   logic addr_load, wr_stb, rd_load;
   logic wr_clock, wr_sram, flag_clear;
   logic down_cap, up_cap;
   stamp_set_type stamp_clean;

   // reset release through two flops
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // pin synchronisers; the third stage only serves edge detection
   // both bus lines reset to their released level so no false start follows reset
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         scl_meta_q <= 1'b1;
         scl_sync_q <= 1'b1;
         scl_del_q <= 1'b1;
      end else begin
         scl_meta_q <= scl_i;
         scl_sync_q <= scl_meta_q;
         scl_del_q <= scl_sync_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sda_meta_q <= 1'b1;
         sda_sync_q <= 1'b1;
         sda_del_q <= 1'b1;
      end else begin
         sda_meta_q <= sda_i;
         sda_sync_q <= sda_meta_q;
         sda_del_q <= sda_sync_q;
      end
   end

   // supply indication resets to main power, so only a real switchover captures
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bak_meta_q <= 1'b0;
         bak_sync_q <= 1'b0;
         bak_del_q <= 1'b0;
      end else begin
         bak_meta_q <= on_backup_i;
         bak_sync_q <= bak_meta_q;
         bak_del_q <= bak_sync_q;
      end
   end

   assign scl_rise = scl_sync_q & ~scl_del_q;
   assign scl_fall = ~scl_sync_q & scl_del_q;
   assign start_det = scl_sync_q & scl_del_q & sda_del_q & ~sda_sync_q;
   assign stop_det = scl_sync_q & scl_del_q & ~sda_del_q & sda_sync_q;
   assign backup_rise = bak_sync_q & ~bak_del_q;
   assign backup_fall = ~bak_sync_q & bak_del_q;

   // byte-level decode of the shift register
   assign byte_done = scl_fall & ~ack_phase_q & (cnt_q == 4'd8) &
      (state_q == ST_CTRL || state_q == ST_ADDR || state_q == ST_WDATA);
   assign ctrl_hit = (shift_q[7:1] == CTRL_CODE);
   assign addr_ok = (shift_q <= SRAM_LAST);
   assign addr_load = byte_done & (state_q == ST_ADDR) & addr_ok;
   assign wr_stb = byte_done & (state_q == ST_WDATA);
   assign rd_load = scl_fall & ack_phase_q & (state_q == ST_RDATA);
   assign wr_clock = wr_stb & (ptr_q <= CLOCK_LAST);
   assign wr_sram = wr_stb & (ptr_q >= SRAM_FIRST) & (ptr_q <= SRAM_LAST);
   assign sram_idx = 6'(ptr_q - SRAM_FIRST);

   // pointer wraps inside the block it sits in
   always_comb begin
      if (ptr_q == CLOCK_LAST) begin
         ptr_next = CLOCK_FIRST;
      end else if (ptr_q == SRAM_LAST) begin
         ptr_next = SRAM_FIRST;
      end else begin
         ptr_next = 8'(ptr_q + 8'h01);
      end
   end

   // bus engine; on backup supply the target goes deaf and lets go of sda
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         ack_phase_q <= 1'b0;
         drive_q <= 1'b0;
         shift_q <= 8'h00;
      end else if (bak_sync_q || stop_det) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         ack_phase_q <= 1'b0;
         drive_q <= 1'b0;
      end else if (start_det) begin
         state_q <= ST_CTRL;
         cnt_q <= 4'h0;
         ack_phase_q <= 1'b0;
         drive_q <= 1'b0;
      end else if (scl_rise) begin
         if (rd_tail_q) begin
            state_q <= ST_IGNORE;
         end else if (!ack_phase_q && cnt_q < 4'd8 &&
               (state_q == ST_CTRL || state_q == ST_ADDR || state_q == ST_WDATA)) begin
            shift_q <= {shift_q[6:0], sda_sync_q};
            cnt_q <= 4'(cnt_q + 4'd1);
         end
      end else if (scl_fall) begin
         if (ack_phase_q) begin
            ack_phase_q <= 1'b0;
            if (state_q == ST_RDATA) begin
               drive_q <= ~rd_byte[7];
               cnt_q <= 4'd1;
            end else begin
               drive_q <= 1'b0;
               cnt_q <= 4'h0;
            end
         end else if (byte_done) begin
            unique case (state_q)
               ST_CTRL: begin
                  if (ctrl_hit) begin
                     drive_q <= 1'b1;
                     ack_phase_q <= 1'b1;
                     state_q <= shift_q[0] ? ST_RDATA : ST_ADDR;
                  end else begin
                     state_q <= ST_IGNORE;
                  end
               end
               ST_ADDR: begin
                  if (addr_ok) begin
                     drive_q <= 1'b1;
                     ack_phase_q <= 1'b1;
                     state_q <= ST_WDATA;
                  end else begin
                     state_q <= ST_IGNORE;
                  end
               end
               ST_WDATA: begin
                  drive_q <= 1'b1;
                  ack_phase_q <= 1'b1;
                  state_q <= ST_WDATA;
               end
               default: begin
                  state_q <= ST_IGNORE;
               end
            endcase
         end else if (state_q == ST_RDATA) begin
            if (cnt_q < 4'd8) begin
               drive_q <= ~tx_q[6];
               cnt_q <= 4'(cnt_q + 4'd1);
            end else begin
               drive_q <= 1'b0;
            end
         end
      end
   end

   // read shifter: loaded as the control acknowledge ends, shifted on later scl falls
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= 8'h00;
      end else if (scl_fall && !bak_sync_q && state_q == ST_RDATA) begin
         if (ack_phase_q) begin
            tx_q <= rd_byte;
         end else if (cnt_q < 4'd8) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // the read byte ends on the controller's acknowledge clock, not on the last data
   // bit, so the target only drops out once the line has been released
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_tail_q <= 1'b0;
      end else if (bak_sync_q || stop_det || start_det) begin
         rd_tail_q <= 1'b0;
      end else if (scl_fall && !ack_phase_q && state_q == ST_RDATA && cnt_q == 4'd8) begin
         rd_tail_q <= 1'b1;
      end else if (scl_rise) begin
         rd_tail_q <= 1'b0;
      end
   end

   // shared pointer; the protected-space logic may also move it
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= 8'h00;
      end else if (addr_load) begin
         ptr_q <= shift_q;
      end else if (wr_stb || rd_load) begin
         ptr_q <= ptr_next;
      end else if (pointer_load_i) begin
         ptr_q <= pointer_value_i;
      end
   end

   // stamp values with unimplemented bits forced low
   always_comb begin
      stamp_clean = clock_calendar_now_i;
      stamp_clean.minutes.unused = 1'b0;
      stamp_clean.hours.unused = 1'b0;
      stamp_clean.date.unused = 2'b00;
   end

   // power-fail logging: only the first loss after a clear is recorded
   assign down_cap = backup_rise & clock_regs_q[WEEKDAY_AND_POWER_STATUS[4:0]][BACKUP_EN_BIT] &
      ~power_loss_q;
   assign up_cap = backup_fall & armed_q;
   assign flag_clear = wr_clock & (ptr_q == WEEKDAY_AND_POWER_STATUS) &
      ~shift_q[POWER_LOSS_BIT];

   // a capture in the same cycle as a software clear wins, so no loss goes unrecorded
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         power_loss_q <= 1'b0;
      end else if (down_cap) begin
         power_loss_q <= 1'b1;
      end else if (flag_clear) begin
         power_loss_q <= 1'b0;
      end
   end

   // power-up capture is armed only by a recorded power-down
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (down_cap) begin
         armed_q <= 1'b1;
      end else if (up_cap) begin
         armed_q <= 1'b0;
      end
   end

   // clock register file, one entry per generate step
   for (genvar i = 0; i < CLOCK_DEPTH; i++) begin : g_clock
      localparam logic [7:0] IDX = 8'(i);
      localparam logic [7:0] WMASK =
         (IDX == POWER_DOWN_STAMP_MINUTES || IDX == POWER_UP_STAMP_MINUTES) ? MINUTES_MASK :
         (IDX == POWER_DOWN_STAMP_HOURS || IDX == POWER_UP_STAMP_HOURS) ? HOURS_MASK :
         (IDX == POWER_DOWN_STAMP_DATE || IDX == POWER_UP_STAMP_DATE) ? DATE_MASK :
         (IDX == POWER_DOWN_STAMP_MONTH || IDX == POWER_UP_STAMP_MONTH) ? MONTH_MASK :
         (IDX == WEEKDAY_AND_POWER_STATUS) ? STATUS_MASK : FULL_MASK;
      localparam bit IS_STAMP = (IDX >= POWER_DOWN_STAMP_MINUTES);
      localparam bit IS_DOWN = IS_STAMP && (IDX <= POWER_DOWN_STAMP_MONTH);
      localparam int SLOT = i % 4;
      logic [7:0] cap_val;

      // slot order in the stamp block: minutes, hours, date, month
      assign cap_val = stamp_clean[SLOT*8 +: 8];

      always_ff @(posedge clk_i or negedge rst_n) begin
         if (!rst_n) begin
            clock_regs_q[i] <= REG_RESET;
         end else if (IS_STAMP && IS_DOWN && down_cap) begin
            clock_regs_q[i] <= cap_val & WMASK;
         end else if (IS_STAMP && !IS_DOWN && up_cap) begin
            clock_regs_q[i] <= cap_val & WMASK;
         end else if (IS_STAMP && flag_clear) begin
            clock_regs_q[i] <= REG_RESET;
         end else if (wr_clock && ptr_q == IDX) begin
            clock_regs_q[i] <= shift_q & WMASK;
         end
      end
   end

   // sram has no reset so contents survive power-on reset
   always_ff @(posedge clk_i) begin
      if (wr_sram) begin
         sram_q[sram_idx] <= shift_q;
      end
   end

   // status view mixes live inputs with stored bits
   always_comb begin
      status_view = clock_regs_q[WEEKDAY_AND_POWER_STATUS[4:0]] & STATUS_MASK;
      status_view[OSC_RUN_BIT] = oscillator_running_flag_i;
      status_view[POWER_LOSS_BIT] = power_loss_q;
   end

   // read data at the current pointer; the protected range is not served here
   always_comb begin
      if (ptr_q == WEEKDAY_AND_POWER_STATUS) begin
         rd_byte = status_view;
      end else if (ptr_q <= CLOCK_LAST) begin
         rd_byte = clock_regs_q[ptr_q[4:0]];
      end else if (ptr_q <= SRAM_LAST) begin
         rd_byte = sram_q[sram_idx];
      end else begin
         rd_byte = 8'h00;
      end
   end

   // open-drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = drive_q;
   assign pointer_o = ptr_q;
   assign power_loss_flag_o = power_loss_q;
   assign backup_supply_enable_o = clock_regs_q[WEEKDAY_AND_POWER_STATUS[4:0]][BACKUP_EN_BIT];

endmodule

// ### inc/clock_calendar_sram_pkg.sv
// constants and field layouts shared by the clock register and sram access logic
package clock_calendar_sram_pkg;

   // bus control code (upper seven bits of the control byte)
   localparam logic [6:0] CTRL_CODE = 7'h6f;
   localparam logic [6:0] PROTECTED_CTRL_CODE = 7'h57;

   // address map
   localparam logic [7:0] CLOCK_FIRST = 8'h00;
   localparam logic [7:0] CLOCK_LAST = 8'h1f;
   localparam logic [7:0] SRAM_FIRST = 8'h20;
   localparam logic [7:0] SRAM_LAST = 8'h5f;
   localparam int SRAM_DEPTH = 64;
   localparam int CLOCK_DEPTH = 32;

   // register offsets
   localparam logic [7:0] WEEKDAY_AND_POWER_STATUS = 8'h03;
   localparam logic [7:0] POWER_DOWN_STAMP_MINUTES = 8'h18;
   localparam logic [7:0] POWER_DOWN_STAMP_HOURS = 8'h19;
   localparam logic [7:0] POWER_DOWN_STAMP_DATE = 8'h1a;
   localparam logic [7:0] POWER_DOWN_STAMP_MONTH = 8'h1b;
   localparam logic [7:0] POWER_UP_STAMP_MINUTES = 8'h1c;
   localparam logic [7:0] POWER_UP_STAMP_HOURS = 8'h1d;
   localparam logic [7:0] POWER_UP_STAMP_DATE = 8'h1e;
   localparam logic [7:0] POWER_UP_STAMP_MONTH = 8'h1f;

   // status register bit positions
   localparam int OSC_RUN_BIT = 5;
   localparam int POWER_LOSS_BIT = 4;
   localparam int BACKUP_EN_BIT = 3;

   // writable bit masks; unimplemented bits read as zero
   localparam logic [7:0] MINUTES_MASK = 8'h7f;
   localparam logic [7:0] HOURS_MASK = 8'h7f;
   localparam logic [7:0] DATE_MASK = 8'h3f;
   localparam logic [7:0] MONTH_MASK = 8'hff;
   localparam logic [7:0] STATUS_MASK = 8'h0f;
   localparam logic [7:0] FULL_MASK = 8'hff;
   localparam logic [7:0] REG_RESET = 8'h00;

   typedef struct packed {
      logic unused;
      logic [2:0] minute_tens_digit;
      logic [3:0] minute_ones_digit;
   } minutes_type;

   // bit 5 is afternoon_flag in 12-hour format, hour tens bit 1 in 24-hour format
   typedef struct packed {
      logic unused;
      logic twelve_hour_sel;
      logic afternoon_flag;
      logic hour_tens_digit;
      logic [3:0] hour_ones_digit;
   } hours_type;

   typedef struct packed {
      logic [1:0] unused;
      logic [1:0] day_of_month_tens;
      logic [3:0] day_of_month_ones;
   } date_type;

   typedef struct packed {
      logic [2:0] weekday_field;
      logic month_tens_bit;
      logic [3:0] month_ones_digit;
   } month_type;

   typedef struct packed {
      month_type month;
      date_type date;
      hours_type hours;
      minutes_type minutes;
   } stamp_set_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CTRL = 3'b001,
      ST_ADDR = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_IGNORE = 3'b101
   } bus_state_type;

endpackage

// ### sim/clock_calendar_sram_i2c_access_assertions.sv
// concurrent checks on the two-wire access port of the clock and sram block
`timescale 1ns/1ps
module clock_calendar_sram_i2c_access_assertions (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic on_backup_i,
   input wire logic pointer_load_i,
   input wire logic [7:0] pointer_value_i,
   input wire logic [7:0] pointer_o,
   input wire logic power_loss_flag_o,
   input wire logic backup_supply_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_sda_open_drain: assert property (sda_o == 1'b0)
      else $error("data value not low");
   chk_backup_silent: assert property (on_backup_i [*6] |-> !sda_oe_o)
      else $error("answer while on backup");
   // refused addresses never reach the pointer, so only a load may put it above sram
   chk_pointer_range: assert property ($changed(pointer_o) && pointer_o > 8'h5f
      |-> $past(pointer_load_i)) else $error("pointer left its blocks");
   chk_load_value: assert property ((scl_i [*6] ##0 pointer_load_i)
      |=> pointer_o == $past(pointer_value_i)) else $error("pointer load lost");
   chk_flag_cause: assert property ($rose(power_loss_flag_o)
      |-> $past(on_backup_i, 2) && $past(backup_supply_enable_o)) else $error("flag set");
   chk_flag_bound: assert property ($rose(on_backup_i) && backup_supply_enable_o
      && !power_loss_flag_o |-> ##[1:6] power_loss_flag_o) else $error("flag not set");
   chk_oe_scl_low: assert property ($changed(sda_oe_o)
      |-> !scl_i && !$past(scl_i)) else $error("data changed with clock high");
   chk_oe_stable_high: assert property (scl_i && $past(scl_i)
      |-> $stable(sda_oe_o)) else $error("data moved during clock high");
   cov_flag_set: cover property ($rose(power_loss_flag_o));
   cov_pointer_load: cover property (pointer_load_i);
   cov_ack: cover property ($rose(sda_oe_o));
endmodule

bind clock_calendar_sram_i2c_access clock_calendar_sram_i2c_access_assertions checker_i (.clk_i, .rst_n_i,
   .scl_i, .sda_o, .sda_oe_o, .on_backup_i, .pointer_load_i, .pointer_value_i, .pointer_o,
   .power_loss_flag_o, .backup_supply_enable_o);

// ### sim/i2c_controller_model.sv
// bus controller model driving the two-wire clock and data lines
`timescale 1ns/1ps
module i2c_controller_model (
   input wire logic clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic pull_q = 1'b0;
   // pulled-up line: low while either party pulls, high once both release
   assign sda_o = !(pull_q || sda_oe_i);
   initial scl_o = 1'b1;
   task automatic tick();
      repeat (5) @(negedge clk_i);
   endtask
   // starts only from an idle bus; repeated start is not modelled
   task automatic start();
      pull_q = 1'b1;
      tick();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      pull_q = 1'b1;
      tick();
      scl_o = 1'b1;
      tick();
      pull_q = 1'b0;
      tick();
   endtask
   // data moves only well inside the clock low phase, never with the clock edge
   task automatic bit_io(input logic b, output logic r);
      tick();
      pull_q = !b;
      tick();
      scl_o = 1'b1;
      tick();
      tick();
      r = sda_o;
      scl_o = 1'b0;
   endtask
   // a read passes 8'hff and ends with the line released, which is the nack
   task automatic xfer(input logic [7:0] d, output logic [7:0] rd, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         rd[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
endmodule

// ### sim/testbench.sv
// self-checking bench for the clock register and sram access port
`timescale 1ns/1ps
module testbench
   import clock_calendar_sram_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic scl_i, sda_i, sda_o, sda_oe_o, power_loss_flag_o, backup_supply_enable_o;
   logic on_backup_i = 1'b0;
   logic oscillator_running_flag_i = 1'b0;
   logic pointer_load_i = 1'b0;
   logic [7:0] pointer_value_i = 8'h00;
   logic [7:0] pointer_o;
   stamp_set_type clock_calendar_now_i = '0;
   stamp_set_type now_q [0:2];
   logic [7:0] mem_q [0:95];
   logic [7:0] ptr = 8'h00;
   logic [7:0] wq [$];
   logic [7:0] wa [$];
   int num_errors = 0;
   int checks_done = 0;
   always #20 clk_i = !clk_i;
   clock_calendar_sram_i2c_access DUT (.clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
      .on_backup_i, .oscillator_running_flag_i, .clock_calendar_now_i, .pointer_load_i,
      .pointer_value_i, .pointer_o, .power_loss_flag_o, .backup_supply_enable_o);
   i2c_controller_model ctl (.clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
   function automatic logic [7:0] mask_of(input logic [7:0] a);
      case (a)
         8'h18, 8'h19, 8'h1c, 8'h1d: return 8'h7f;
         8'h1a, 8'h1e: return 8'h3f;
         default: return 8'hff;
      endcase
   endfunction
   function automatic logic [7:0] nxt(input logic [7:0] a);
      return a == 8'h1f ? 8'h00 : a == 8'h5f ? 8'h20 : a + 8'h01;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // writes the bytes queued in wq from address a
   task automatic wr(input logic [7:0] a);
      logic ack;
      logic [7:0] v;
      ctl.start();
      ctl.xfer(8'hde, v, ack);
      check(8'(ack), 8'h01);
      ctl.xfer(a, v, ack);
      check(8'(ack), 8'(a <= 8'h5f));
      if (a <= 8'h5f) ptr = a;
      check(pointer_o, ptr);
      foreach (wq[i]) begin
         ctl.xfer(wq[i], v, ack);
         check(8'(ack), 8'(a <= 8'h5f));
         if (a <= 8'h5f) begin
            mem_q[ptr] = wq[i] & mask_of(ptr);
            wa.push_back(ptr);
            ptr = nxt(ptr);
         end
         check(pointer_o, ptr);
      end
      ctl.stop();
      // every status write here has the flag bit low, which wipes the stamps
      if (a == 8'h03 && wq.size() > 0) for (int i = 24; i < 32; i++) mem_q[i] = 8'h00;
   endtask
   task automatic rd(input logic [7:0] a, input logic set);
      logic ack;
      logic [7:0] v;
      wq = {};
      if (set) wr(a);
      ctl.start();
      ctl.xfer(8'hdf, v, ack);
      check(8'(ack), 8'h01);
      ctl.xfer(8'hff, v, ack);
      ctl.stop();
      check(v, mem_q[a]);
      ptr = nxt(a);
      check(pointer_o, ptr);
   endtask
   task automatic rd_range(input logic [7:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         rd(a, 1'b1);
         a = nxt(a);
      end
   endtask
   task automatic bad(input logic [7:0] c);
      logic ack;
      logic [7:0] v;
      ctl.start();
      ctl.xfer(c, v, ack);
      ctl.stop();
      check(8'(ack), 8'h00);
   endtask
   task automatic pulse(input stamp_set_type dn, input stamp_set_type up);
      clock_calendar_now_i = dn;
      on_backup_i = 1'b1;
      repeat (10) @(negedge clk_i);
      bad(8'hde);
      clock_calendar_now_i = up;
      on_backup_i = 1'b0;
      repeat (10) @(negedge clk_i);
   endtask
   initial begin
      void'($urandom(32'h8b8ba4ea));
      oscillator_running_flag_i = 1'($urandom);
      for (int i = 0; i < 3; i++) now_q[i] = $urandom;
      for (int i = 0; i < 32; i++) mem_q[i] = 8'h00;
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (5) @(negedge clk_i);
      check({6'h00, power_loss_flag_o, backup_supply_enable_o}, 8'h00);
      rd_range(8'h18, 8);
      for (int i = 0; i < 10; i++) wq.push_back(i < 8 ? 8'hff : 8'($urandom));
      wr(8'h18);
      rd_range(8'h18, 10);
      wa = {};
      for (int k = 0; k < 3; k++) begin
         wq = {};
         for (int i = 0; i < 6; i++) wq.push_back(8'($urandom));
         wr(k == 0 ? 8'h5c : 8'h20 + 8'($urandom % 64));
      end
      foreach (wa[i]) rd(wa[i], 1'b1);
      bad(8'hae);
      bad(8'haf);
      for (int i = 0; i < 3; i++) bad(8'hde ^ (8'h02 << ($urandom % 7)));
      wq = {8'($urandom)};
      wr(8'h60);
      wr(8'h60 + 8'($urandom % 160));
      for (int j = 0; j < 2; j++) begin
         pointer_value_i = j ? wa[0] : 8'hf0 + 8'($urandom % 8);
         pointer_load_i = 1'b1;
         @(negedge clk_i);
         pointer_load_i = 1'b0;
         @(negedge clk_i);
         check(pointer_o, pointer_value_i);
      end
      rd(wa[0], 1'b0);
      wq = {8'h08};
      wr(8'h03);
      check(8'(backup_supply_enable_o), 8'h01);
      pulse(now_q[0], now_q[1]);
      check(8'(power_loss_flag_o), 8'h01);
      mem_q[3] = {2'b00, oscillator_running_flag_i, 5'h18};
      rd(8'h03, 1'b1);
      for (int i = 0; i < 4; i++) begin
         mem_q[24 + i] = now_q[0][8*i +: 8] & mask_of(8'(24 + i));
         mem_q[28 + i] = now_q[1][8*i +: 8] & mask_of(8'(28 + i));
      end
      pulse(now_q[2], now_q[2]);
      rd_range(8'h18, 8);
      wq = {8'h08};
      wr(8'h03);
      check(8'(power_loss_flag_o), 8'h00);
      rd_range(8'h18, 8);
      mem_q[3] = {2'b00, oscillator_running_flag_i, 5'h08};
      rd(8'h03, 1'b1);
      rst_n_i = 1'b0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (5) @(negedge clk_i);
      check({power_loss_flag_o, backup_supply_enable_o, 6'h00}, 8'h00);
      check(pointer_o, 8'h00);
      for (int i = 0; i < 32; i++) mem_q[i] = 8'h00;
      rd(wa[0], 1'b1);
      wrap_up();
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end
endmodule
